/* rtl/pse_pkg.sv */
// Constants, types and helpers for the status-word and exception-entry block.
// Assumes one core clock; every user of these names imports the whole package.
// Contract
// RULE1 - Decode seven five-bit mode encodings
// RULE2 - One current, five saved status words
// RULE3 - Modes bank own stack and link
// RULE4 - Low eight bits form control group
// RULE5 - Mask bits block their interrupt kind
// RULE6 - State flag selects compact or wide
// RULE7 - Software never flips state flag directly; here a privileged CSW write sets bit 5 as written
// RULE8 - Invalid mode locks until reset
// RULE9 - Flags set by operations, tested outside
// RULE10 - Control group writable only when privileged
// RULE11 - Software preserves reserved status bits
// RULE12 - Simultaneous exceptions served in priority
// RULE13 - Call, trap, link: plus four/two
// RULE14 - Interrupt link is skipped address plus four
// RULE15 - Fetch abort link is address plus four
// RULE16 - Data abort link is address plus eight
// RULE17 - Reset leaves supervisor link undefined
// RULE18 - Entry copies current word to saved
// RULE19 - Entry forces mode of exception
// RULE20 - Entry redirects fetch, may set masks
// RULE21 - Entry clears state flag, wide start
// RULE22 - Restore brings back earlier state flag
// RULE23 - Vectors at fixed low word addresses
// RULE24 - No saved word in user, system
package pse_pkg;

   // ----------------------------------------
   // Mode encodings
   // ----------------------------------------
   localparam logic [4:0] MODE_USER = 5'h10; // RULE1
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1B;
   localparam logic [4:0] MODE_SYS = 5'h1F;

   // ----------------------------------------
   // Status word layout and reset value
   // ----------------------------------------
   localparam int FLAGS_LSB = 28;
   localparam int CTRL_MSB = 7; // RULE4
   localparam int BIT_IRQ_MASK = 7;
   localparam int BIT_FIQ_MASK = 6;
   localparam int BIT_COMPACT = 5;
   localparam int MODE_MSB = 4;
   localparam logic [31:0] CSW_RESET = 32'h000000D3;

   // ----------------------------------------
   // Vectors and link offsets
   // ----------------------------------------
   localparam logic [31:0] VEC_RESET = 32'h00000000; // RULE23
   localparam logic [31:0] VEC_UNDEF = 32'h00000004;
   localparam logic [31:0] VEC_CALL = 32'h00000008;
   localparam logic [31:0] VEC_FETCH = 32'h0000000C;
   localparam logic [31:0] VEC_DATA = 32'h00000010;
   localparam logic [31:0] VEC_IRQ = 32'h00000018;
   localparam logic [31:0] VEC_FIQ = 32'h0000001C;
   localparam logic [31:0] LINK_WIDE = 32'h00000004;
   localparam logic [31:0] LINK_COMPACT = 32'h00000002;
   localparam logic [31:0] LINK_DATA = 32'h00000008;

   // ----------------------------------------
   // Register port map
   // ----------------------------------------
   localparam logic [7:0] REG_CSW = 8'h00;
   localparam logic [7:0] REG_SSW = 8'h04;
   localparam logic [7:0] REG_SP = 8'h08;
   localparam logic [7:0] REG_LINK = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam int STAT_BUSY = 0;
   localparam int STAT_LOCK = 1;
   localparam int STAT_PRIV = 2;
   localparam int STAT_PEND_LSB = 8;
   localparam int CMD_RESTORE = 0;
   localparam int PEND_UNDEF = 0;
   localparam int PEND_CALL = 1;
   localparam int PEND_FETCH = 2;
   localparam int PEND_DATA = 3;
   localparam int NUM_BANKS = 6;

   typedef enum logic [2:0] {
      EXC_NONE = 3'h0, EXC_RESET = 3'h1, EXC_UNDEF = 3'h2, EXC_CALL = 3'h3,
      EXC_FETCH = 3'h4, EXC_DATA = 3'h5, EXC_IRQ = 3'h6, EXC_FIQ = 3'h7
   } pse_exc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_LINK = 2'h1, ST_SAVE = 2'h2, ST_FORCE = 2'h3
   } pse_state_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic pse_mode_valid(input logic [4:0] m);
      pse_mode_valid = (m == MODE_USER) || (m == MODE_FIQ) || (m == MODE_IRQ) || (m == MODE_SVC)
         || (m == MODE_ABT) || (m == MODE_UND) || (m == MODE_SYS); // RULE1
   endfunction

   function automatic logic pse_mode_priv(input logic [4:0] m);
      pse_mode_priv = pse_mode_valid(m) && (m != MODE_USER);
   endfunction

   // Bank 0 is shared by user and system; it owns no saved word
   function automatic logic [2:0] pse_bank_of(input logic [4:0] m);
      case (m)
         MODE_FIQ: pse_bank_of = 3'h1;
         MODE_IRQ: pse_bank_of = 3'h2;
         MODE_SVC: pse_bank_of = 3'h3;
         MODE_ABT: pse_bank_of = 3'h4;
         MODE_UND: pse_bank_of = 3'h5;
         default: pse_bank_of = 3'h0;
      endcase
   endfunction

   function automatic logic [4:0] pse_exc_mode(input pse_exc_t k);
      case (k)
         EXC_UNDEF: pse_exc_mode = MODE_UND;
         EXC_FETCH, EXC_DATA: pse_exc_mode = MODE_ABT;
         EXC_IRQ: pse_exc_mode = MODE_IRQ;
         EXC_FIQ: pse_exc_mode = MODE_FIQ;
         default: pse_exc_mode = MODE_SVC;
      endcase
   endfunction

   function automatic logic [31:0] pse_exc_vector(input pse_exc_t k);
      case (k)
         EXC_UNDEF: pse_exc_vector = VEC_UNDEF;
         EXC_CALL: pse_exc_vector = VEC_CALL;
         EXC_FETCH: pse_exc_vector = VEC_FETCH;
         EXC_DATA: pse_exc_vector = VEC_DATA;
         EXC_IRQ: pse_exc_vector = VEC_IRQ;
         EXC_FIQ: pse_exc_vector = VEC_FIQ;
         default: pse_exc_vector = VEC_RESET;
      endcase
   endfunction

   function automatic logic [31:0] pse_link_offset(input pse_exc_t k, input logic compact);
      case (k)
         EXC_UNDEF, EXC_CALL: pse_link_offset = compact ? LINK_COMPACT : LINK_WIDE; // RULE13
         EXC_DATA: pse_link_offset = LINK_DATA; // RULE16
         default: pse_link_offset = LINK_WIDE; // RULE14 RULE15
      endcase
   endfunction

endpackage

/* rtl/pse_arbiter.sv */
// Priority pick among pending exceptions and synchronised interrupt pins.
// Assumes pins are asynchronous and active low; other inputs share the clock.
`timescale 1ns/100ps
module pse_arbiter
   import pse_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic irq_req_n,
   input wire logic fiq_req_n,
   input wire logic [3:0] pend,
   input wire logic irq_mask_bit,
   input wire logic fiq_mask_bit,
   input wire logic boundary,
   output pse_exc_t grant
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic irq_s1, irq_s2, fiq_s1, fiq_s2;
   logic irq_act, fiq_act;

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         irq_s1 <= 1'b1;
         irq_s2 <= 1'b1;
         fiq_s1 <= 1'b1;
         fiq_s2 <= 1'b1;
      end
      else
      begin
         irq_s1 <= irq_req_n;
         irq_s2 <= irq_s1;
         fiq_s1 <= fiq_req_n;
         fiq_s2 <= fiq_s1;
      end

   // Interrupt levels are looked at only at instruction ends
   assign irq_act = boundary && !irq_s2 && !irq_mask_bit; // RULE5
   assign fiq_act = boundary && !fiq_s2 && !fiq_mask_bit; // RULE5

   // ----------------------------------------
   // Fixed priority
   // ----------------------------------------
   always_comb
   begin
      grant = EXC_NONE;
      if (pend[PEND_DATA]) // RULE12
         grant = EXC_DATA;
      else if (fiq_act)
         grant = EXC_FIQ;
      else if (irq_act)
         grant = EXC_IRQ;
      else if (pend[PEND_FETCH])
         grant = EXC_FETCH;
      else if (pend[PEND_UNDEF])
         grant = EXC_UNDEF;
      else if (pend[PEND_CALL])
         grant = EXC_CALL;
   end

endmodule

/* rtl/pse_bank.sv */
// Banked stack and link registers and the five saved status words.
// Assumes one writer per port per cycle; the caller resolves priority.
`timescale 1ns/100ps
module pse_bank
   import pse_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [2:0] rd_bank,
   output logic [31:0] sp_rd,
   output logic [31:0] link_rd,
   output logic [31:0] ssw_rd,
   input wire logic sp_we,
   input wire logic [31:0] sp_wdata,
   input wire logic link_we,
   input wire logic [2:0] link_wbank,
   input wire logic [31:0] link_wdata,
   input wire logic ssw_we,
   input wire logic [2:0] ssw_wbank,
   input wire logic [31:0] ssw_wdata
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Stack and link data carry no reset; nothing may rely on them before a write
   logic [31:0] sp_mem [NUM_BANKS];
   logic [31:0] link_mem [NUM_BANKS];
   logic [31:0] ssw_mem [1:NUM_BANKS-1];

   always_ff @(posedge clock)
      if (sp_we)
         sp_mem[rd_bank] <= sp_wdata; // RULE3

   always_ff @(posedge clock)
      if (link_we)
         link_mem[link_wbank] <= link_wdata; // RULE3

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         for (int i = 1; i < NUM_BANKS; i++)
            ssw_mem[i] <= 32'h00000000;
      end
      else if (ssw_we && (ssw_wbank != 3'h0)) // RULE2 RULE24
         ssw_mem[ssw_wbank] <= ssw_wdata;

   // ----------------------------------------
   // Read side
   // ----------------------------------------
   assign sp_rd = sp_mem[rd_bank];
   assign link_rd = link_mem[rd_bank];
   assign ssw_rd = (rd_bank == 3'h0) ? 32'h00000000 : ssw_mem[rd_bank]; // RULE24

endmodule

/* rtl/pse_psr_exception_entry.sv */
// Current status word, register port and the exception-entry sequencer.
// Assumes the core holds instr_addr steady while entry_busy is high.
`timescale 1ns/100ps
module pse_psr_exception_entry
   import pse_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic flags_we,
   input wire logic [3:0] flags_in,
   input wire logic undef_req,
   input wire logic call_req,
   input wire logic fetch_abort_req,
   input wire logic data_abort_req,
   input wire logic branch_link_req,
   input wire logic irq_req_n,
   input wire logic fiq_req_n,
   input wire logic instr_boundary,
   input wire logic [31:0] instr_addr,
   output logic fetch_redirect,
   output logic [31:0] fetch_addr,
   output logic instr_state_out,
   output logic [4:0] mode_out,
   output logic [3:0] flags_out,
   output logic entry_busy,
   output logic mode_locked
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   pse_state_t state, next_state;
   pse_exc_t grant, ent_kind;
   logic [31:0] csw;
   logic [31:0] ent_addr;
   logic ent_compact;
   logic [3:0] pend, pend_set, pend_clr;
   logic [4:0] cur_mode;
   logic [2:0] cur_bank, tgt_bank;
   logic priv;
   logic take;
   logic restore;
   logic wr_csw, wr_ssw, wr_sp, wr_link;
   logic [31:0] sp_rd, link_rd, ssw_rd;
   logic link_we, ssw_we;
   logic [2:0] link_wbank, ssw_wbank;
   logic [31:0] link_wdata, ssw_wdata;
   logic [31:0] next_rdata;

   assign cur_mode = csw[MODE_MSB:0];
   assign cur_bank = pse_bank_of(cur_mode);
   assign tgt_bank = pse_bank_of(pse_exc_mode(ent_kind));
   assign priv = pse_mode_priv(cur_mode);
   assign wr_csw = reg_wr && (reg_addr == REG_CSW);
   assign wr_ssw = reg_wr && (reg_addr == REG_SSW);
   assign wr_sp = reg_wr && (reg_addr == REG_SP);
   assign wr_link = reg_wr && (reg_addr == REG_LINK);
   // Restore is refused outside exception modes and while locked
   assign restore = reg_wr && (reg_addr == REG_STAT) && reg_wdata[CMD_RESTORE]
      && (cur_bank != 3'h0) && !mode_locked; // RULE24
   assign take = (state == ST_IDLE) && !mode_locked && (grant != EXC_NONE); // RULE8

   assign instr_state_out = csw[BIT_COMPACT]; // RULE6
   assign mode_out = cur_mode;
   assign flags_out = csw[31:FLAGS_LSB]; // RULE9
   assign entry_busy = (state != ST_IDLE);

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   pse_arbiter u_arbiter (
      .clock(clock),
      .nrst(nrst),
      .irq_req_n(irq_req_n),
      .fiq_req_n(fiq_req_n),
      .pend(pend),
      .irq_mask_bit(csw[BIT_IRQ_MASK]),
      .fiq_mask_bit(csw[BIT_FIQ_MASK]),
      .boundary(instr_boundary),
      .grant(grant)
   );

   pse_bank u_bank (
      .clock(clock),
      .nrst(nrst),
      .rd_bank(cur_bank),
      .sp_rd(sp_rd),
      .link_rd(link_rd),
      .ssw_rd(ssw_rd),
      .sp_we(wr_sp),
      .sp_wdata(reg_wdata),
      .link_we(link_we),
      .link_wbank(link_wbank),
      .link_wdata(link_wdata),
      .ssw_we(ssw_we),
      .ssw_wbank(ssw_wbank),
      .ssw_wdata(ssw_wdata)
   );

   // ----------------------------------------
   // Pending synchronous exceptions
   // ----------------------------------------
   assign pend_set = {data_abort_req, fetch_abort_req, call_req, undef_req};

   always_comb
   begin
      pend_clr = 4'h0;
      if (take)
      begin
         case (grant)
            EXC_UNDEF: pend_clr[PEND_UNDEF] = 1'b1;
            EXC_CALL: pend_clr[PEND_CALL] = 1'b1;
            EXC_FETCH: pend_clr[PEND_FETCH] = 1'b1;
            EXC_DATA: pend_clr[PEND_DATA] = 1'b1;
            default: pend_clr = 4'h0;
         endcase
      end
   end

   // A request in the cycle its bit is cleared survives
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         pend <= 4'h0;
      else
         pend <= (pend & ~pend_clr) | pend_set; // RULE12

   // ----------------------------------------
   // Entry sequencer
   // ----------------------------------------
   always_comb
   begin
      case (state)
         ST_IDLE: next_state = take ? ST_LINK : ST_IDLE;
         ST_LINK: next_state = ST_SAVE;
         ST_SAVE: next_state = ST_FORCE;
         ST_FORCE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Reset enters through the force step alone, so reset never writes the supervisor link
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         state <= ST_FORCE; // RULE17
      else
         state <= next_state; // RULE12

   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         ent_kind <= EXC_RESET;
         ent_addr <= 32'h00000000;
         ent_compact <= 1'b0;
      end
      else if (take)
      begin
         ent_kind <= grant;
         ent_addr <= instr_addr;
         ent_compact <= csw[BIT_COMPACT];
      end

   // ----------------------------------------
   // Link and saved word writes
   // ----------------------------------------
   // Entry owns the link port; a branch-link or port write in that cycle is dropped
   always_comb
   begin
      link_we = 1'b0;
      link_wbank = cur_bank;
      link_wdata = reg_wdata;
      if (state == ST_LINK)
      begin
         link_we = 1'b1;
         link_wbank = tgt_bank;
         link_wdata = ent_addr + pse_link_offset(ent_kind, ent_compact); // RULE13 RULE14 RULE15 RULE16
      end
      else if (branch_link_req)
      begin
         link_we = 1'b1;
         link_wdata = instr_addr + (csw[BIT_COMPACT] ? LINK_COMPACT : LINK_WIDE); // RULE13
      end
      else if (wr_link)
         link_we = 1'b1;
   end

   always_comb
   begin
      ssw_we = 1'b0;
      ssw_wbank = cur_bank;
      ssw_wdata = reg_wdata;
      if (state == ST_SAVE)
      begin
         ssw_we = 1'b1;
         ssw_wbank = tgt_bank;
         ssw_wdata = csw; // RULE18
      end
      else if (wr_ssw)
         ssw_we = 1'b1; // RULE24
   end

   // ----------------------------------------
   // Current status word
   // ----------------------------------------
   // Reserved bits are stored as written so read-modify-write keeps them
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         csw <= CSW_RESET;
      else if (state == ST_FORCE)
      begin
         csw[MODE_MSB:0] <= pse_exc_mode(ent_kind); // RULE19
         csw[BIT_IRQ_MASK] <= 1'b1; // RULE20
         csw[BIT_FIQ_MASK] <= csw[BIT_FIQ_MASK] | (ent_kind == EXC_FIQ) | (ent_kind == EXC_RESET);
         csw[BIT_COMPACT] <= 1'b0; // RULE21
      end
      else if (restore)
         csw <= ssw_rd; // RULE22
      else if (wr_csw)
      begin
         csw[31:CTRL_MSB+1] <= reg_wdata[31:CTRL_MSB+1]; // RULE9
         if (priv)
            csw[CTRL_MSB:0] <= reg_wdata[CTRL_MSB:0]; // RULE10
      end
      else if (flags_we)
         csw[31:FLAGS_LSB] <= flags_in; // RULE9

   // An illegal mode cannot be left without reset
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         mode_locked <= 1'b0;
      else if (!pse_mode_valid(cur_mode))
         mode_locked <= 1'b1; // RULE8

   // ----------------------------------------
   // Fetch redirect
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         fetch_redirect <= 1'b0;
         fetch_addr <= VEC_RESET;
      end
      else
      begin
         fetch_redirect <= (state == ST_FORCE); // RULE20
         if (state == ST_FORCE)
            fetch_addr <= pse_exc_vector(ent_kind); // RULE23
      end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   always_comb
   begin
      next_rdata = 32'h00000000;
      case (reg_addr)
         REG_CSW: next_rdata = csw;
         REG_SSW: next_rdata = ssw_rd; // RULE24
         REG_SP: next_rdata = sp_rd;
         REG_LINK: next_rdata = link_rd;
         REG_STAT:
         begin
            next_rdata[STAT_BUSY] = entry_busy;
            next_rdata[STAT_LOCK] = mode_locked;
            next_rdata[STAT_PRIV] = priv;
            next_rdata[STAT_PEND_LSB+3:STAT_PEND_LSB] = pend;
         end
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Data stands one cycle only, zero otherwise
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         reg_rdata <= 32'h00000000;
      else
         reg_rdata <= reg_rd ? next_rdata : 32'h00000000;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   valid_mode_nolock_a: assert property ( // RULE1
      (!mode_locked && pse_mode_valid(cur_mode)) |=> !mode_locked)
      else $error("valid mode caused lock");

   irq_masked_a: assert property ( // RULE5
      csw[BIT_IRQ_MASK] |-> (grant != EXC_IRQ))
      else $error("masked normal interrupt granted");

   fiq_masked_a: assert property ( // RULE5
      (take && csw[BIT_FIQ_MASK]) |-> (grant != EXC_FIQ))
      else $error("masked fast interrupt taken");

   entry_order_a: assert property ( // RULE12
      (state == ST_LINK) |=> (state == ST_SAVE) ##1 (state == ST_FORCE) ##1 (state == ST_IDLE))
      else $error("entry steps out of order");

   link_value_a: assert property ( // RULE13
      (take && (grant == EXC_CALL)) |=> link_we && (link_wbank == 3'h3)
      && (link_wdata == $past(instr_addr) + ($past(csw[BIT_COMPACT]) ? LINK_COMPACT : LINK_WIDE)))
      else $error("call link value wrong");

   data_abort_link_a: assert property ( // RULE16
      (take && (grant == EXC_DATA)) |=> (link_wdata == $past(instr_addr) + LINK_DATA) && (link_wbank == 3'h4))
      else $error("data abort link value wrong");

   save_word_a: assert property ( // RULE18
      (state == ST_LINK) |=> ssw_we && (ssw_wdata == $past(csw)) && (ssw_wbank == $past(tgt_bank)))
      else $error("status word not saved");

   force_redirect_a: assert property ( // RULE19
      (state == ST_FORCE) |=> fetch_redirect && (mode_out == pse_exc_mode($past(ent_kind)))
      && (fetch_addr == pse_exc_vector($past(ent_kind))) && csw[BIT_IRQ_MASK])
      else $error("mode or vector wrong after entry");

   wide_start_a: assert property ( // RULE21
      fetch_redirect |-> !instr_state_out ##1 !fetch_redirect)
      else $error("entry not in wide state");

   user_ctrl_a: assert property ( // RULE10
      (wr_csw && !priv && (state == ST_IDLE)) |=> (csw[CTRL_MSB:0] == $past(csw[CTRL_MSB:0])))
      else $error("control group changed in user mode");

   restore_state_a: assert property ( // RULE22
      (restore && (state == ST_IDLE)) |=> (instr_state_out == $past(ssw_rd[BIT_COMPACT])))
      else $error("state flag not restored");

   no_saved_word_a: assert property ( // RULE24
      (wr_ssw && (cur_bank == 3'h0) && (state == ST_IDLE) && !flags_we) |=> (csw == $past(csw)))
      else $error("user saved write disturbed status");

   call_entry_c: cover property ((state == ST_FORCE) && (ent_kind == EXC_CALL));
   fiq_entry_c: cover property ((state == ST_FORCE) && (ent_kind == EXC_FIQ));
   restore_c: cover property (restore ##1 !instr_state_out);
   stacked_c: cover property (take ##4 take);

endmodule

/* test/pse_psr_exception_entry_tb.sv */
// Self-checking bench for the status-word and exception-entry block.
// Assumes the block alone, driven through its own ports by a 100 MHz clock.
`timescale 1ns/100ps
module pse_psr_exception_entry_tb
   import pse_pkg::*;
;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clock = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic flags_we = 1'h0, irq_n = 1'h1, fiq_n = 1'h1, bnd = 1'h1, bl = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, instr_addr = 32'h0, rdata_q;
   logic [3:0] req = 4'h0, flags_in = 4'h0;
   logic [31:0] reg_rdata, fetch_addr;
   logic fetch_redirect, instr_state_out, entry_busy, mode_locked;
   logic [4:0] mode_out;
   logic [3:0] flags_out;
   int num_errors = 0;
   int tests_run = 0;

   always #5 clock = ~clock;

   // Request bits: 0 undef, 1 call, 2 fetch abort, 3 data abort
   pse_psr_exception_entry pse_psr_exception_entry_i (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags_we(flags_we),
      .flags_in(flags_in), .undef_req(req[0]), .call_req(req[1]), .fetch_abort_req(req[2]),
      .data_abort_req(req[3]), .branch_link_req(bl), .irq_req_n(irq_n), .fiq_req_n(fiq_n),
      .instr_boundary(bnd), .instr_addr(instr_addr), .fetch_redirect(fetch_redirect),
      .fetch_addr(fetch_addr), .instr_state_out(instr_state_out), .mode_out(mode_out),
      .flags_out(flags_out), .entry_busy(entry_busy), .mode_locked(mode_locked));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Ends one step past the edge so registered effects have landed
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
      #1;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a, rdata_q);
      chk(what, exp, rdata_q);
   endtask

   // Address held until redirect; wait bounded to 20 cycles
   task ent(input logic [3:0] r, input logic [31:0] a, v, input logic [4:0] m, input logic [31:0] lnk);
      int n;
      @(posedge clock);
      instr_addr <= a;
      req <= r;
      @(posedge clock);
      req <= 4'h0;
      n = 0;
      while (fetch_redirect !== 1'h1 && n < 20)
      begin
         @(posedge clock);
         #1;
         if (n == 0)
            chk("busy", 32'h1, {31'h0, entry_busy});
         n++;
      end
      if (n < 20)
      begin
         chk("idle", 32'h0, {31'h0, entry_busy});
         chk("vector", v, fetch_addr);
         chk("mode", {27'h0, m}, {27'h0, mode_out});
         rdc(REG_LINK, lnk, "link");
      end
      else
      begin
         num_errors++;
         $display("FAIL redirect expected 1 seen 0");
         finish_test();
      end
   endtask

   task finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge clock);
      nrst <= 1'h1;
      @(posedge clock);
      #1;
      chk("reset redirect", 32'h1, {31'h0, fetch_redirect});
      chk("reset vector", VEC_RESET, fetch_addr);
      rdc(REG_CSW, CSW_RESET, "reset word");
      wr(REG_CSW, 32'h00000010);
      rdc(REG_SSW, 32'h0, "user saved");
      wr(REG_CSW, 32'hF00000D3);
      rdc(REG_CSW, 32'hF0000010, "user control");
      @(posedge clock);
      flags_in <= 4'hA;
      flags_we <= 1'h1;
      @(posedge clock);
      flags_we <= 1'h0;
      #1;
      chk("flags", 32'hA, {28'h0, flags_out});
      ent(4'h2, 32'h100, VEC_CALL, MODE_SVC, 32'h104);
      rdc(REG_SSW, 32'hA0000010, "call saved");
      rdc(REG_CSW, 32'hA0000093, "call word");
      wr(REG_SSW, 32'hA00000B3);
      wr(REG_STAT, 32'h1);
      chk("compact", 32'h1, {31'h0, instr_state_out});
      ent(4'h1, 32'h200, VEC_UNDEF, MODE_UND, 32'h202);
      chk("entry state", 32'h0, {31'h0, instr_state_out});
      rdc(REG_SSW, 32'hA00000B3, "trap saved");
      wr(REG_STAT, 32'h1);
      chk("restored state", 32'h1, {31'h0, instr_state_out});
      ent(4'h8, 32'h300, VEC_DATA, MODE_ABT, 32'h308);
      ent(4'h4, 32'h340, VEC_FETCH, MODE_ABT, 32'h344);
      wr(REG_CSW, 32'h00000093);
      irq_n <= 1'h0;
      repeat (12) @(posedge clock);
      chk("masked", {27'h0, MODE_SVC}, {27'h0, mode_out});
      instr_addr <= 32'h400;
      wr(REG_CSW, 32'h00000013);
      ent(4'h0, 32'h400, VEC_IRQ, MODE_IRQ, 32'h404);
      irq_n <= 1'h1;
      fiq_n <= 1'h0;
      ent(4'h0, 32'h500, VEC_FIQ, MODE_FIQ, 32'h504);
      fiq_n <= 1'h1;
      rdc(REG_CSW, 32'h000000D1, "fast word");
      rdc(REG_SSW, 32'h00000092, "fast saved");
      wr(REG_CSW, 32'h000000D3);
      rdc(REG_LINK, 32'h104, "banked link");
      @(posedge clock);
      instr_addr <= 32'h600;
      bl <= 1'h1;
      @(posedge clock);
      bl <= 1'h0;
      rdc(REG_LINK, 32'h604, "branch link");
      wr(REG_CSW, 32'h0000001F);
      wr(REG_SSW, 32'hFFFFFFFF);
      rdc(REG_SSW, 32'h0, "system saved");
      rdc(REG_CSW, 32'h0000001F, "system word");
      wr(REG_CSW, 32'h00000015);
      @(posedge clock);
      #1;
      chk("locked", 32'h1, {31'h0, mode_locked});
      rdc(REG_STAT, 32'h00000002, "lock status");
      @(posedge clock);
      #1;
      chk("read idle", 32'h0, reg_rdata);
      finish_test();
   end
endmodule
